// >>> common/ecb_pkg.sv
// constants and types shared by the external code bus control block
package ecb_pkg;
    localparam int         REG_AW       = 12;
    localparam int         REG_DW       = 8;
    localparam int         XADDR_W      = 20;
    localparam int         XDATA_W      = 16;
    localparam int         FIELD_W      = 2;
    localparam int         CNT_W        = 2;
    localparam int         PAGE_LSB     = 8;
    localparam int         PAGE_W       = XADDR_W - PAGE_LSB;

    localparam logic [11:0] REG_BTL     = 12'h468;
    localparam logic [11:0] REG_BTH     = 12'h469;
    localparam logic [11:0] REG_CFG     = 12'h46A;
    localparam logic [11:0] REG_STAT    = 12'h46B;

    localparam logic [7:0] BTL_RST      = 8'hEF;
    localparam logic [7:0] BTH_RST      = 8'hFF;
    localparam logic [7:0] CFG_RST      = 8'h00;
    localparam logic [7:0] BTL_MASK     = 8'hEF;
    localparam logic [7:0] CFG_MASK     = 8'h1F;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;

    // field positions, low bit of each two-bit field, or the bit itself for one-bit flags
    localparam int         BTH_DW       = 6;
    localparam int         BTH_DWA      = 4;
    localparam int         BTH_DR       = 2;
    localparam int         BTH_DRA      = 0;
    localparam int         BTL_WM       = 6;
    localparam int         BTL_LATCH_W  = 5;
    localparam int         BTL_CR       = 2;
    localparam int         BTL_CRA      = 0;
    localparam int         CFG_STRETCH_OFF = 4;
    localparam int         CFG_BUS_OFF  = 3;
    localparam int         STAT_SRC     = 0;
    localparam int         STAT_BUSY    = 1;
    localparam int         STAT_WAIT    = 2;

    localparam logic [19:0] INT_CODE_LIMIT = 20'h08000;
    localparam logic [1:0] LATCH_SHORT  = 2'h0;
    localparam logic [1:0] LATCH_LONG   = 2'h1;
    localparam logic [1:0] CNT_ZERO     = 2'h0;
    localparam logic [1:0] CNT_ONE      = 2'h1;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_LATCH  = 2'b01,
        ST_ACCESS = 2'b10,
        ST_DONE   = 2'b11
    } ecb_state_t;
endpackage

// >>> dv/ecb_mem_model.sv
// external memory and wait agent on the far side of the bus
`timescale 1ns/10ps
module ecb_mem_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [19:0] extAddr,
    input  wire logic        programFetchStrobeN,
    input  wire logic        readStrobeN,
    input  wire logic        writeStrobeN,
    input  wire logic        srcLevel,
    input  wire logic [3:0]  waitLen,
    output logic [15:0]      extDataIn,
    output logic             codeSourceWait
);
    logic        live;
    logic        strobeQ;
    logic        rdNow;
    logic        anyNow;
    logic [3:0]  waitCnt;
    logic [15:0] lastRd;

    assign rdNow  = !programFetchStrobeN || !readStrobeN;
    assign anyNow = rdNow || !writeStrobeN;
    assign extDataIn = rdNow ? ({extAddr[7:0], extAddr[15:8]} ^ 16'h5A3C) : ~lastRd;
    assign codeSourceWait = live ? (waitCnt != 4'h0) : srcLevel;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            live    <= 1'b0;
            strobeQ <= 1'b0;
            waitCnt <= 4'h0;
            lastRd  <= 16'h0000;
        end else begin
            live    <= 1'b1;
            strobeQ <= anyNow;
            if (anyNow && !strobeQ) begin
                waitCnt <= waitLen;
            end else if (waitCnt != 4'h0) begin
                waitCnt <= waitCnt - 4'h1;
            end
            if (rdNow) begin
                lastRd <= extDataIn;
            end
        end
    end
endmodule

// >>> dv/tb_external_code_bus_control.sv
// self-checking bench for the external code bus control block
`timescale 1ns/10ps
module tb_external_code_bus_control;
    logic clk, rst_n, regWr, regRd, reqValid, reqCode, reqWrite, reqReady, intFetch;
    logic reqDone, pin, latchStrobe, programFetchStrobeN, readStrobeN, writeStrobeN;
    logic srcLevel, srcQ, havePage, extDataOe;
    logic [11:0] regAddr, lastPage;
    logic [7:0]  regWrData, regRdData, btl, bth, cfg;
    logic [19:0] reqAddr, extAddr;
    logic [15:0] reqWrData, reqRdData, extDataIn, extDataOut;
    logic [3:0]  waitLen;
    int          errTotal, checksDone, cyc, i;
    int          seed = 32'h9a0643b0;

    ecb_ctrl dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .reqValid(reqValid),
        .reqCode(reqCode), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWrData(reqWrData),
        .reqReady(reqReady), .intFetch(intFetch), .reqDone(reqDone), .reqRdData(reqRdData),
        .codeSourceWait(pin), .extAddr(extAddr), .latchStrobe(latchStrobe),
        .programFetchStrobeN(programFetchStrobeN), .readStrobeN(readStrobeN),
        .writeStrobeN(writeStrobeN), .extDataOut(extDataOut), .extDataOe(extDataOe),
        .extDataIn(extDataIn));
    ecb_mem_model mem_u (.clk(clk), .rst_n(rst_n), .extAddr(extAddr),
        .programFetchStrobeN(programFetchStrobeN), .readStrobeN(readStrobeN),
        .writeStrobeN(writeStrobeN), .srcLevel(srcLevel), .waitLen(waitLen),
        .extDataIn(extDataIn), .codeSourceWait(pin));

    ////////////////////////////////////////////////////////////////////////
    task automatic closeOut;
        $display("checks %0d errors %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic regW(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a; regWrData <= d; regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        if (a == ecb_pkg::REG_BTL) btl = d & ecb_pkg::BTL_MASK;
        if (a == ecb_pkg::REG_BTH) bth = d;
        if (a == ecb_pkg::REG_CFG) cfg = d & ecb_pkg::CFG_MASK;
    endtask

    task automatic regR(input logic [11:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        regAddr <= a; regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(what, {12'h000, exp}, {12'h000, regRdData});
    endtask

    task automatic doReset(input logic src);
        rst_n <= 1'b0; srcLevel <= src;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        havePage = 1'b0; srcQ = src;
        btl = ecb_pkg::BTL_RST; bth = ecb_pkg::BTH_RST; cfg = ecb_pkg::CFG_RST;
        repeat (2) @(posedge clk);
    endtask

    task automatic acc(input logic c, w, input logic [19:0] a, input logic [15:0] d);
        int n, lat, lowN, bad;
        logic ie, intExp, needL;
        logic [1:0] f;
        n = 0; lat = 0; lowN = 0; bad = 0;
        @(posedge clk);
        reqValid <= 1'b1; reqCode <= c; reqWrite <= w; reqAddr <= a; reqWrData <= d;
        #1;
        while (reqReady !== 1'b1 && n < 50) begin
            @(posedge clk); #1 n++;
        end
        chk("reqReady", 20'h1, {19'h0, reqReady});
        ie = intFetch;
        intExp = c && srcQ && (a < ecb_pkg::INT_CODE_LIMIT);
        @(posedge clk);
        reqValid <= 1'b0;
        chk("intFetch", {19'h0, intExp}, {19'h0, ie});
        needL = !havePage || a[19:8] != lastPage;
        if (!intExp) begin
            havePage = 1'b1; lastPage = a[19:8];
        end
        f = c ? (needL ? btl[1:0] : btl[3:2]) : w ? (needL ? bth[5:4] : bth[7:6])
            : (needL ? bth[1:0] : bth[3:2]);
        n = 0;
        do begin
            #1 n++;
            lat += latchStrobe;
            lowN += c ? !programFetchStrobeN : w ? !writeStrobeN : !readStrobeN;
            bad += c ? (!readStrobeN || !writeStrobeN) : intExp ? !programFetchStrobeN
                : (!programFetchStrobeN || (w ? !readStrobeN : !writeStrobeN));
            bad += (extDataOe !== !writeStrobeN) || (!writeStrobeN && extDataOut !== d);
            if (intExp || reqDone !== 1'b1) @(posedge clk);
        end while ((intExp ? n < 4 : reqDone !== 1'b1) && n < 60);
        chk("other strobes", 20'h0, 20'(bad));
        if (intExp) return;
        chk("done seen", 20'h1, {19'h0, reqDone});
        chk("latch cycles", needL ? (btl[5] ? 20'h2 : 20'h1) : 20'h0, 20'(lat));
        if (waitLen == 4'h0 || cfg[4]) begin
            chk("strobe cycles", 20'(f) + 20'h1, 20'(lowN));
        end else begin
            chk("stretched", 20'h1, 20'(lowN > f + 1 && lowN <= f + 4 + waitLen));
        end
        if (!w) chk("read data", {4'h0, a[7:0], a[15:8]} ^ 20'h05A3C, {4'h0, reqRdData});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errTotal++;
            closeOut;
        end
    end

    initial begin
        rst_n = 1'b0; srcLevel = 1'b1; waitLen = 4'h0; regAddr = 12'h000; regWrData = 8'h00;
        regWr = 1'b0; regRd = 1'b0; reqValid = 1'b0; reqCode = 1'b0; reqWrite = 1'b0;
        reqAddr = 20'h00000; reqWrData = 16'h0000;
        doReset(1'b1);
        regR(ecb_pkg::REG_BTL, ecb_pkg::BTL_RST, "low timing reset");
        regR(ecb_pkg::REG_BTH, ecb_pkg::BTH_RST, "high timing reset");
        regR(ecb_pkg::REG_CFG, ecb_pkg::CFG_RST, "config reset");
        regR(12'h400, 8'h00, "unmapped");
        regR(ecb_pkg::REG_STAT, 8'h01, "status source one");
        acc(1'b1, 1'b0, 20'h07FFE, 16'h0000);
        acc(1'b1, 1'b0, 20'h08000, 16'h0000);
        acc(1'b1, 1'b0, 20'h08002, 16'h0000);
        acc(1'b0, 1'b0, 20'h12345, 16'h0000);
        acc(1'b0, 1'b1, 20'h12346, 16'hBEEF);
        for (i = 0; i < 12; i++) begin
            regW(ecb_pkg::REG_BTL, 8'($random(seed)));
            regW(ecb_pkg::REG_BTH, 8'($random(seed)));
            regR(ecb_pkg::REG_BTL, btl, "low timing");
            regR(ecb_pkg::REG_BTH, bth, "high timing");
            repeat (3) acc(1'($random(seed)), 1'($random(seed)),
                20'h18000 | (20'($random(seed)) & 20'h00303), 16'($random(seed)));
        end
        regW(ecb_pkg::REG_BTL, 8'h0F);
        regW(ecb_pkg::REG_BTH, 8'hFF);
        waitLen <= 4'h6;
        acc(1'b1, 1'b0, 20'h19000, 16'h0000);
        acc(1'b0, 1'b0, 20'h1A000, 16'h0000);
        regR(ecb_pkg::REG_STAT, 8'h05, "status wait seen");
        regW(ecb_pkg::REG_CFG, 8'h10);
        acc(1'b1, 1'b0, 20'h1B000, 16'h0000);
        regR(ecb_pkg::REG_STAT, 8'h01, "status wait off");
        waitLen <= 4'h0;
        repeat (10) @(posedge clk);
        doReset(1'b0);
        regR(ecb_pkg::REG_STAT, 8'h00, "status source zero");
        acc(1'b1, 1'b0, 20'h00100, 16'h0000);
        acc(1'b1, 1'b0, 20'h00102, 16'h0000);
        closeOut;
    end
endmodule

// >>> hdl/ecb_ctrl.sv
// external code bus control: fetch strobe, code source capture, wait stretch
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module ecb_ctrl (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [7:0]       regRdData,
    input  wire logic        reqValid,
    input  wire logic        reqCode,
    input  wire logic        reqWrite,
    input  wire logic [19:0] reqAddr,
    input  wire logic [15:0] reqWrData,
    output logic             reqReady,
    output logic             intFetch,
    output logic             reqDone,
    output logic [15:0]      reqRdData,
    input  wire logic        codeSourceWait,
    output logic [19:0]      extAddr,
    output logic             latchStrobe,
    output logic             programFetchStrobeN,
    output logic             readStrobeN,
    output logic             writeStrobeN,
    output logic [15:0]      extDataOut,
    output logic             extDataOe,
    input  wire logic [15:0] extDataIn
);
    ecb_pkg::ecb_state_t stateQ;
    ecb_pkg::ecb_state_t stateD;
    logic [7:0]  timingLowQ;
    logic [7:0]  timingHighQ;
    logic [7:0]  busConfigQ;
    logic [7:0]  statusWord;
    logic        captureDoneQ;
    logic        codeSrcQ;
    logic        waitSync;
    logic        waitActive;
    logic        waitSeenQ;
    logic        stretchOff;
    logic        busOff;
    logic        reqInternal;
    logic        start;
    logic        needLatch;
    logic [1:0]  accLen;
    logic [1:0]  latchLen;
    logic [1:0]  cntQ;
    logic [1:0]  cntD;
    logic [1:0]  accLenQ;
    logic        kindCodeQ;
    logic        kindWrQ;
    logic        curCode;
    logic        curWr;
    logic        lastValidQ;
    logic [11:0] lastPageQ;

    ////////////////////////////////////////////////////////////////////////
    ecb_regs u_regs (
        .clk         (clk),
        .rst_n       (rst_n),
        .regAddr     (regAddr),
        .regWrData   (regWrData),
        .regWr       (regWr),
        .regRd       (regRd),
        .statusIn    (statusWord),
        .regRdData   (regRdData),
        .timingLowQ  (timingLowQ),
        .timingHighQ (timingHighQ),
        .busConfigQ  (busConfigQ)
    );

    ecb_sync2 u_waitSync (
        .clk     (clk),
        .rst_n   (rst_n),
        .asyncIn (codeSourceWait),
        .syncOut (waitSync)
    );

    assign stretchOff = busConfigQ[ecb_pkg::CFG_STRETCH_OFF];
    assign busOff     = busConfigQ[ecb_pkg::CFG_BUS_OFF];
    assign statusWord = {5'h00, waitSeenQ, (stateQ != ecb_pkg::ST_IDLE), codeSrcQ};

    ////////////////////////////////////////////////////////////////////////
    // capture at reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            captureDoneQ <= 1'b0;
            codeSrcQ     <= 1'b0;
        end else if (!captureDoneQ) begin
            captureDoneQ <= 1'b1;
            codeSrcQ     <= codeSourceWait;
        end
    end

    assign waitActive = captureDoneQ & waitSync & ~stretchOff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitSeenQ <= 1'b0;
        end else if (stateQ == ecb_pkg::ST_ACCESS && waitActive) begin
            waitSeenQ <= 1'b1;
        end else if (start) begin
            waitSeenQ <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // code source routing
    assign reqInternal = reqCode & codeSrcQ & (reqAddr < ecb_pkg::INT_CODE_LIMIT);
    assign reqReady    = captureDoneQ & (stateQ == ecb_pkg::ST_IDLE);
    assign intFetch    = reqValid & reqReady & reqInternal;
    assign start       = reqValid & reqReady & ~reqInternal;

    // new address latch on page change, or when no page is held after reset or bus off
    assign needLatch = ~lastValidQ | (reqAddr[ecb_pkg::XADDR_W-1:ecb_pkg::PAGE_LSB] != lastPageQ);
    assign latchLen  = timingLowQ[ecb_pkg::BTL_LATCH_W] ? ecb_pkg::LATCH_LONG : ecb_pkg::LATCH_SHORT;

    always_comb begin
        if (reqCode) begin
            accLen = needLatch ? timingLowQ[ecb_pkg::BTL_CRA +: ecb_pkg::FIELD_W]
                               : timingLowQ[ecb_pkg::BTL_CR +: ecb_pkg::FIELD_W];
        end else if (reqWrite) begin
            accLen = needLatch ? timingHighQ[ecb_pkg::BTH_DWA +: ecb_pkg::FIELD_W]
                               : timingHighQ[ecb_pkg::BTH_DW +: ecb_pkg::FIELD_W];
        end else begin
            accLen = needLatch ? timingHighQ[ecb_pkg::BTH_DRA +: ecb_pkg::FIELD_W]
                               : timingHighQ[ecb_pkg::BTH_DR +: ecb_pkg::FIELD_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        stateD = stateQ;
        cntD   = cntQ;
        case (stateQ)
            ecb_pkg::ST_IDLE: begin
                if (start && busOff) begin
                    stateD = ecb_pkg::ST_DONE;
                end else if (start && needLatch) begin
                    stateD = ecb_pkg::ST_LATCH;
                    cntD   = latchLen;
                end else if (start) begin
                    stateD = ecb_pkg::ST_ACCESS;
                    cntD   = accLen;
                end
            end
            ecb_pkg::ST_LATCH: begin
                if (cntQ == ecb_pkg::CNT_ZERO) begin
                    stateD = ecb_pkg::ST_ACCESS;
                    cntD   = accLenQ;
                end else begin
                    cntD = cntQ - ecb_pkg::CNT_ONE;
                end
            end
            ecb_pkg::ST_ACCESS: begin
                if (cntQ != ecb_pkg::CNT_ZERO) begin
                    cntD = cntQ - ecb_pkg::CNT_ONE;
                end else if (!waitActive) begin
                    stateD = ecb_pkg::ST_DONE;
                end
            end
            ecb_pkg::ST_DONE: begin
                stateD = ecb_pkg::ST_IDLE;
            end
            default: begin
                stateD = ecb_pkg::ST_IDLE;
                cntD   = ecb_pkg::CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= ecb_pkg::ST_IDLE;
            cntQ   <= ecb_pkg::CNT_ZERO;
        end else begin
            stateQ <= stateD;
            cntQ   <= cntD;
        end
    end

    // request capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            kindCodeQ  <= 1'b0;
            kindWrQ    <= 1'b0;
            accLenQ    <= ecb_pkg::CNT_ZERO;
            extAddr    <= 20'h00000;
            extDataOut <= 16'h0000;
        end else if (start) begin
            kindCodeQ  <= reqCode;
            kindWrQ    <= reqWrite & ~reqCode;
            accLenQ    <= accLen;
            extAddr    <= reqAddr;
            extDataOut <= reqWrData;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lastValidQ <= 1'b0;
            lastPageQ  <= 12'h000;
        end else if (busOff) begin
            lastValidQ <= 1'b0;
        end else if (start && needLatch) begin
            lastValidQ <= 1'b1;
            lastPageQ  <= reqAddr[ecb_pkg::XADDR_W-1:ecb_pkg::PAGE_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin outputs registered from next state
    assign curCode = (stateQ == ecb_pkg::ST_IDLE) ? reqCode : kindCodeQ;
    assign curWr   = (stateQ == ecb_pkg::ST_IDLE) ? (reqWrite & ~reqCode) : kindWrQ;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latchStrobe         <= 1'b0;
            programFetchStrobeN <= 1'b1;
            readStrobeN         <= 1'b1;
            writeStrobeN        <= 1'b1;
            extDataOe           <= 1'b0;
        end else begin
            // latch strobe only in latch phase
            latchStrobe         <= (stateD == ecb_pkg::ST_LATCH);
            // fetch strobe for external code only
            programFetchStrobeN <= ~(stateD == ecb_pkg::ST_ACCESS && curCode);
            readStrobeN         <= ~(stateD == ecb_pkg::ST_ACCESS && !curCode && !curWr);
            writeStrobeN        <= ~(stateD == ecb_pkg::ST_ACCESS && curWr);
            extDataOe           <= (stateD == ecb_pkg::ST_ACCESS && curWr);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reqDone   <= 1'b0;
            reqRdData <= 16'h0000;
        end else begin
            reqDone <= (stateD == ecb_pkg::ST_DONE);
            if (stateQ == ecb_pkg::ST_ACCESS && stateD == ecb_pkg::ST_DONE && !kindWrQ) begin
                reqRdData <= extDataIn;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_fetch_low;
        @(posedge clk) disable iff (!rst_n)
        stateQ == ecb_pkg::ST_ACCESS && kindCodeQ |-> !programFetchStrobeN;
    endproperty
    a_fetch_low: assert property (p_fetch_low) else $error("fetch strobe high in code access");

    property p_fetch_idle;
        @(posedge clk) disable iff (!rst_n)
        !programFetchStrobeN |-> stateQ == ecb_pkg::ST_ACCESS && kindCodeQ && readStrobeN;
    endproperty
    a_fetch_idle: assert property (p_fetch_idle) else $error("fetch strobe low outside fetch");

    property p_src_hold;
        @(posedge clk) disable iff (!rst_n)
        captureDoneQ |=> captureDoneQ && $stable(codeSrcQ);
    endproperty
    a_src_hold: assert property (p_src_hold) else $error("captured code source changed");

    property p_src_ext;
        @(posedge clk) disable iff (!rst_n)
        reqValid && reqReady && reqCode && !codeSrcQ && !busOff |=> stateQ != ecb_pkg::ST_IDLE;
    endproperty
    a_src_ext: assert property (p_src_ext) else $error("fetch not sent external");

    property p_src_int;
        @(posedge clk) disable iff (!rst_n)
        reqValid && reqReady && reqCode && codeSrcQ
            |-> intFetch == (reqAddr < ecb_pkg::INT_CODE_LIMIT);
    endproperty
    a_src_int: assert property (p_src_int) else $error("internal routing wrong");

    property p_wait_after;
        @(posedge clk) disable iff (!rst_n)
        !captureDoneQ |-> !waitActive;
    endproperty
    a_wait_after: assert property (p_wait_after) else $error("wait used before capture");

    property p_stretch;
        @(posedge clk) disable iff (!rst_n)
        stateQ == ecb_pkg::ST_ACCESS && cntQ == ecb_pkg::CNT_ZERO && waitActive
            |=> stateQ == ecb_pkg::ST_ACCESS && !reqDone;
    endproperty
    a_stretch: assert property (p_stretch) else $error("access not extended");

    property p_release;
        @(posedge clk) disable iff (!rst_n)
        stateQ == ecb_pkg::ST_ACCESS && cntQ == ecb_pkg::CNT_ZERO && !waitActive
            |=> reqDone ##1 !reqDone;
    endproperty
    a_release: assert property (p_release) else $error("access did not end on release");

    property p_latch;
        @(posedge clk) disable iff (!rst_n)
        $rose(latchStrobe) |-> $past(needLatch) && $past(start) && !$past(busOff);
    endproperty
    a_latch: assert property (p_latch) else $error("latch strobe without need");
endmodule

// >>> hdl/ecb_regs.sv
// bus timing and configuration registers behind the plain register port
`timescale 1ns/10ps
module ecb_regs (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    input  wire logic [7:0]  statusIn,
    output logic [7:0]       regRdData,
    output logic [7:0]       timingLowQ,
    output logic [7:0]       timingHighQ,
    output logic [7:0]       busConfigQ
);
    ////////////////////////////////////////////////////////////////////////
    // upper timing byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timingHighQ <= ecb_pkg::BTH_RST;
        end else if (regWr && regAddr == ecb_pkg::REG_BTH) begin
            timingHighQ <= regWrData;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timingLowQ <= ecb_pkg::BTL_RST;
        end else if (regWr && regAddr == ecb_pkg::REG_BTL) begin
            timingLowQ <= regWrData & ecb_pkg::BTL_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busConfigQ <= ecb_pkg::CFG_RST;
        end else if (regWr && regAddr == ecb_pkg::REG_CFG) begin
            busConfigQ <= regWrData & ecb_pkg::CFG_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= ecb_pkg::ZERO_BYTE;
        end else if (regRd) begin
            case (regAddr)
                ecb_pkg::REG_BTL:  regRdData <= timingLowQ;
                ecb_pkg::REG_BTH:  regRdData <= timingHighQ;
                ecb_pkg::REG_CFG:  regRdData <= busConfigQ;
                ecb_pkg::REG_STAT: regRdData <= statusIn;
                default:           regRdData <= ecb_pkg::ZERO_BYTE;
            endcase
        end else begin
            regRdData <= ecb_pkg::ZERO_BYTE;
        end
    end

    property p_bth_write;
        @(posedge clk) disable iff (!rst_n)
        regWr && regAddr == ecb_pkg::REG_BTH |=> timingHighQ == $past(regWrData);
    endproperty
    a_bth_write: assert property (p_bth_write) else $error("upper timing byte not written");

    // lower byte write lands, bit 4 stays clear
    property p_btl_write;
        @(posedge clk) disable iff (!rst_n)
        regWr && regAddr == ecb_pkg::REG_BTL
            |=> timingLowQ == ($past(regWrData) & ecb_pkg::BTL_MASK);
    endproperty
    a_btl_write: assert property (p_btl_write) else $error("lower timing byte not written");
endmodule

// >>> hdl/ecb_sync2.sv
// two-stage synchroniser for the shared wait pin
`timescale 1ns/10ps
module ecb_sync2 (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1Q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1Q <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stage1Q <= asyncIn;
            syncOut <= stage1Q;
        end
    end
endmodule
